// ---- svw_cpu_model.sv ----
// svw_cpu_model.sv: processor side: services the kick wire, drives manual reset.
// assumes the bench picks the kick mode; changes land on the falling edge.
module svw_cpu_model (
	input  wire       clk_sys_i,
	input  wire       kick_input_o,
	input  wire       kick_input_oe_o,
	input  wire       mr_drive_i,
	input  wire       mr_level_i,
	input  wire [1:0] kick_mode_i,
	input  wire [7:0] kick_per_i,
	output wire       manual_rst_n_o,
	output logic      kick_wire_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_r = 8'h00;
	logic       lvl_r = 1'h0;
	// open pin reads high through the pull-up
	assign manual_rst_n_o = mr_drive_i ? mr_level_i : 1'h1;
	// modes: 0 hold level, 1 toggle, 2 pulse of two cycles, 3 let go
	always @(negedge clk_sys_i) begin
		cnt_r <= (cnt_r >= kick_per_i) ? 8'h00 : cnt_r + 8'h01;
		if (kick_mode_i == 2'h1 && cnt_r == kick_per_i)
			lvl_r <= !lvl_r;
		else if (kick_mode_i == 2'h2)
			lvl_r <= (cnt_r < 8'h02);
	end
	// the weak drive only shows once the processor lets go
	always_comb
		kick_wire_o = (kick_mode_i == 2'h3) ? (kick_input_oe_o ? kick_input_o : !lvl_r) : lvl_r;
endmodule

// ---- svw_kick_detect.v ----
// svw_kick_detect.v: synchroniser and both-edge detector for the kick pin.
// assumes the pin is asynchronous; a pulse must span one clock edge.
`include "svw_map.vh"

module svw_kick_detect (
	// clock and reset
	input  wire clk_sys_i,
	input  wire rst_i,
	// pin side
	input  wire kick_input_i,
	// one-cycle pulse on every rising or falling edge
	output wire kick_edge_o
);

	reg meta_r;
	reg sync_r;
	reg prev_r;

	// no filtering: a 50 ns pulse spans at least one 25 ns edge and is kept
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= `SVW_KICK_RST;
			sync_r <= `SVW_KICK_RST;
			prev_r <= `SVW_KICK_RST;
		end else begin
			meta_r <= kick_input_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// either direction counts as a service
	assign kick_edge_o = sync_r ^ prev_r;

endmodule

// ---- svw_map.vh ----
// svw_map.vh: constants of the supervisory reset and watchdog block.
// assumes a 40 MHz system clock; included by every svw design file.
`ifndef SVW_MAP_VH
`define SVW_MAP_VH

// clock rate, used to turn times into cycle counts
`define SVW_CLK_KHZ       40000

// counter width, large enough for the longest count
`define SVW_CNT_W         26

// reset hold period, least time, in ms and in cycles
`define SVW_HOLD_MS       140
`define SVW_HOLD_CYC      ((`SVW_HOLD_MS * `SVW_CLK_KHZ))

// kick window, nominal, in ms and in cycles
`define SVW_KICK_MS       1600
`define SVW_KICK_CYC      ((`SVW_KICK_MS * `SVW_CLK_KHZ))

// self-service driver goes high for the last eighth of the window
`define SVW_SELF_NUM      7
`define SVW_SELF_DEN      8

// manual reset glitch rejection, in ns and in cycles (rounded up)
`define SVW_MR_GLITCH_NS  100
`define SVW_MR_DEB_CYC    ((`SVW_MR_GLITCH_NS * `SVW_CLK_KHZ + 999999) / 1000000)
`define SVW_DEB_W         3

// reset values
`define SVW_MR_RST        1'b1
`define SVW_KICK_RST      1'b0

// bit positions in the cause vector
`define SVW_CAUSE_UV      0
`define SVW_CAUSE_MR      1
`define SVW_CAUSE_WD      2
`define SVW_CAUSE_W       3

`endif

// ---- svw_mr_filter.v ----
// svw_mr_filter.v: synchroniser and debouncer for the manual reset pin.
// assumes the pin is asynchronous and pulled up outside when left open.
`include "svw_map.vh"

module svw_mr_filter (
	// clock and reset
	input  wire clk_sys_i,
	input  wire rst_i,
	// pin side
	input  wire manual_rst_n_i,
	// filtered level, low while a manual reset is held
	output wire mr_level_n_o
);

	// the glitch count is worked out wide, then cut to the counter width on purpose
	localparam integer          DEB_N    = `SVW_MR_DEB_CYC - 1;
	localparam [`SVW_DEB_W-1:0] DEB_LAST = DEB_N[`SVW_DEB_W-1:0];

	reg                  meta_r;
	reg                  sync_r;
	reg                  stable_r;
	reg [`SVW_DEB_W-1:0] deb_r;

	// two-stage synchroniser; the first stage feeds only the second
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= `SVW_MR_RST;
			sync_r <= `SVW_MR_RST;
		end else begin
			meta_r <= manual_rst_n_i;
			sync_r <= meta_r;
		end
	end

	// a new level must hold for the whole glitch window before it is taken,
	// so switch bounce and short spikes never reach the reset logic
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			stable_r <= `SVW_MR_RST;
			deb_r    <= {`SVW_DEB_W{1'b0}};
		end else if (sync_r == stable_r) begin
			deb_r <= {`SVW_DEB_W{1'b0}};
		end else if (deb_r == DEB_LAST) begin
			stable_r <= sync_r;
			deb_r    <= {`SVW_DEB_W{1'b0}};
		end else begin
			deb_r <= deb_r + 1'b1;
		end
	end

	assign mr_level_n_o = stable_r;

endmodule

// ---- svw_top.v ----
// svw_top.v: supervisory reset generator with manual reset and watchdog.
// assumes an undervoltage flag from an analog comparator, asynchronous to
// clk_sys_i; pull-up on the manual reset wire and weak-drive resolution of
// the kick wire are done by the surrounding wiring.
`include "svw_map.vh"

module svw_top #(
	parameter [`SVW_CNT_W-1:0] HOLD_CYC = `SVW_HOLD_CYC,
	parameter [`SVW_CNT_W-1:0] KICK_CYC = `SVW_KICK_CYC
) (
	// clock and reset
	input  wire                  clk_sys_i,
	input  wire                  rst_i,
	// supply monitor
	input  wire                  undervolt_i,
	// manual reset pin, active low
	input  wire                  manual_rst_n_i,
	// kick pin, driven weakly by this block
	input  wire                  kick_input_i,
	output wire                  kick_input_o,
	output wire                  kick_input_oe_o,
	// reset outputs
	output wire                  rst_n_o,
	output wire                  rst_o,
	// status
	output wire                  wdog_trip_o,
	output wire [`SVW_CAUSE_W-1:0] cause_o
);

	localparam [2:0] ST_RUN   = 3'b001;
	localparam [2:0] ST_CAUSE = 3'b010;
	localparam [2:0] ST_HOLD  = 3'b100;

	localparam [`SVW_CNT_W-1:0] HOLD_LAST = HOLD_CYC - 1'b1;
	localparam [`SVW_CNT_W-1:0] KICK_LAST = KICK_CYC - 1'b1;
	localparam [`SVW_CNT_W-1:0] SELF_HIGH = (KICK_CYC / `SVW_SELF_DEN) * `SVW_SELF_NUM;

	// supply flag synchroniser
	reg                    uv_meta_r;
	reg                    uv_sync_r;

	// reset sequencer
	reg [2:0]              state_r;
	reg [2:0]              state_nxt;
	reg [`SVW_CNT_W-1:0]   hold_r;
	reg [`SVW_CNT_W-1:0]   hold_nxt;
	reg                    rst_r;
	reg                    rst_n_r;
	wire                   asserted_nxt;

	// watchdog
	reg [`SVW_CNT_W-1:0]   wd_r;
	reg [`SVW_CNT_W-1:0]   wd_nxt;
	reg                    wd_expire_r;
	reg                    wd_expire_nxt;
	reg                    drive_r;
	reg                    drive_oe_r;

	// cause record
	reg [`SVW_CAUSE_W-1:0] cause_r;
	reg [`SVW_CAUSE_W-1:0] cause_nxt;

	wire                   mr_level_n;
	wire                   mr_low;
	wire                   kick_edge;
	wire                   wd_clear;
	wire                   cause_any;
	wire [`SVW_CAUSE_W-1:0] cause_now;

	// one-cycle count step shared by both counters
	function [`SVW_CNT_W-1:0] cnt_step;
		input [`SVW_CNT_W-1:0] cnt;
		input                  up;
		begin
			if (up)
				cnt_step = cnt + 1'b1;
			else
				cnt_step = cnt - 1'b1;
		end
	endfunction

	svw_mr_filter u_mr_filter (
		.clk_sys_i      (clk_sys_i),
		.rst_i          (rst_i),
		.manual_rst_n_i (manual_rst_n_i),
		.mr_level_n_o   (mr_level_n)
	);

	svw_kick_detect u_kick_detect (
		.clk_sys_i    (clk_sys_i),
		.rst_i        (rst_i),
		.kick_input_i (kick_input_i),
		.kick_edge_o  (kick_edge)
	);

	// the comparator output is not related to clk_sys_i
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			uv_meta_r <= 1'b0;
			uv_sync_r <= 1'b0;
		end else begin
			uv_meta_r <= undervolt_i;
			uv_sync_r <= uv_meta_r;
		end
	end

	// an open manual input reads high through the pull-up and stays idle
	assign mr_low = ~mr_level_n;

	assign cause_now[`SVW_CAUSE_UV] = uv_sync_r;
	assign cause_now[`SVW_CAUSE_MR] = mr_low;
	assign cause_now[`SVW_CAUSE_WD] = wd_expire_r;
	assign cause_any = |cause_now;

	// sequencer: a cause parks the machine in ST_CAUSE, reloading the hold
	// count every cycle, so the hold always runs from the last cause
	always @* begin
		state_nxt = state_r;
		hold_nxt  = hold_r;
		case (state_r)
			ST_RUN: begin
				if (cause_any) begin
					state_nxt = ST_CAUSE;
					hold_nxt  = HOLD_LAST;
				end
			end
			ST_CAUSE: begin
				hold_nxt = HOLD_LAST;
				if (!cause_any)
					state_nxt = ST_HOLD;
			end
			ST_HOLD: begin
				if (cause_any) begin
					state_nxt = ST_CAUSE;
					hold_nxt  = HOLD_LAST;
				end else if (hold_r == {`SVW_CNT_W{1'b0}}) begin
					state_nxt = ST_RUN;
				end else begin
					hold_nxt = cnt_step(hold_r, 1'b0);
				end
			end
			default: begin
				state_nxt = ST_CAUSE;
				hold_nxt  = HOLD_LAST;
			end
		endcase
	end

	assign asserted_nxt = (state_nxt != ST_RUN);

	// block reset behaves like power-up: reset asserted, full hold to follow
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_HOLD;
			hold_r  <= HOLD_LAST;
			rst_r   <= 1'b1;
			rst_n_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			hold_r  <= hold_nxt;
			rst_r   <= asserted_nxt;
			rst_n_r <= ~asserted_nxt;
		end
	end

	// watchdog clears on asserted reset, on a held manual reset and on any
	// kick edge; it reads the registered reset so it restarts from zero on
	// the first cycle after release
	assign wd_clear = rst_r | mr_low | kick_edge;

	always @* begin
		wd_nxt        = wd_r;
		wd_expire_nxt = 1'b0;
		if (wd_clear) begin
			wd_nxt = {`SVW_CNT_W{1'b0}};
		end else if (wd_r == KICK_LAST) begin
			wd_nxt        = {`SVW_CNT_W{1'b0}};
			wd_expire_nxt = 1'b1;
		end else begin
			wd_nxt = cnt_step(wd_r, 1'b1);
		end
	end

	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wd_r        <= {`SVW_CNT_W{1'b0}};
			wd_expire_r <= 1'b0;
		end else begin
			wd_r        <= wd_nxt;
			wd_expire_r <= wd_expire_nxt;
		end
	end

	// weak self-service driver: high only in the last eighth of the window.
	// with the pin floating the wire follows it, the rising edge clears the
	// counter, the drive drops and a second edge follows, so the watchdog
	// never expires; a strong external driver simply overrides it
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			drive_r    <= `SVW_KICK_RST;
			drive_oe_r <= 1'b1;
		end else begin
			drive_r    <= (wd_nxt >= SELF_HIGH);
			drive_oe_r <= 1'b1;
		end
	end

	// cause record: bits collect while reset is asserted and restart with
	// the first cause after a release; an event in the clearing cycle wins
	always @* begin
		cause_nxt = cause_r;
		if (cause_any) begin
			if (rst_r)
				cause_nxt = cause_r | cause_now;
			else
				cause_nxt = cause_now;
		end
	end

	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			cause_r <= {`SVW_CAUSE_W{1'b0}};
		else
			cause_r <= cause_nxt;
	end

	assign rst_o           = rst_r;
	assign rst_n_o         = rst_n_r;
	assign kick_input_o    = drive_r;
	assign kick_input_oe_o = drive_oe_r;
	assign wdog_trip_o     = wd_expire_r;
	assign cause_o         = cause_r;

endmodule

// ---- svw_top_assertions.sv ----
// svw_top_assertions.sv: port timing checks of svw_top, bound to it.
// assumes one clock and a kick wire resolved outside the block.
`include "svw_map.vh"
module svw_top_chk #(
	parameter [`SVW_CNT_W-1:0] HOLD_CYC = 20,
	parameter [`SVW_CNT_W-1:0] KICK_CYC = 64
) (
	input wire                     clk_sys_i,
	input wire                     rst_i,
	input wire                     undervolt_i,
	input wire                     manual_rst_n_i,
	input wire                     kick_input_i,
	input wire                     kick_input_o,
	input wire                     kick_input_oe_o,
	input wire                     rst_n_o,
	input wire                     rst_o,
	input wire                     wdog_trip_o,
	input wire [`SVW_CAUSE_W-1:0] cause_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] quiet_r;
	logic [7:0] wd_r;
	logic       kick_q_r;
	// quiet_r saturates so a long idle spell cannot wrap into a false short hold
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			quiet_r  <= 8'h00;
			wd_r     <= 8'h00;
			kick_q_r <= 1'h0;
		end else begin
			kick_q_r <= kick_input_i;
			quiet_r  <= (undervolt_i || !manual_rst_n_i || wdog_trip_o) ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hff};
			wd_r     <= (rst_o || kick_q_r != kick_input_i) ? 8'h00 : wd_r + 8'h01;
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	a_out_compl: assert property (rst_o != rst_n_o) else $error("reset outputs not complements");
	a_uv_force: assert property (undervolt_i |-> ##3 rst_o) else $error("undervoltage did not reset");
	a_mr_force: assert property (!manual_rst_n_i [*8] |-> rst_o) else $error("manual low did not reset");
	a_trip_rst: assert property (wdog_trip_o |=> rst_o && cause_o[2]) else $error("expiry did not reset");
	a_held_quiet: assert property (rst_o |-> !wdog_trip_o) else $error("watchdog ran during reset");
	a_hold_min: assert property ($fell(rst_o) |-> quiet_r >= HOLD_CYC) else $error("hold too short");
	a_hold_max: assert property (rst_o |-> quiet_r <= HOLD_CYC + 9) else $error("hold too long");
	a_trip_time: assert property (wdog_trip_o |-> wd_r >= KICK_CYC - 4 && wd_r <= KICK_CYC + 4)
		else $error("expiry at wrong count");
	a_self_rise: assert property ($rose(kick_input_o) |-> wd_r >= KICK_CYC / 8 * 7 - 4 && wd_r <= KICK_CYC / 8 * 7 + 4)
		else $error("weak drive rose at wrong count");
	a_oe_on: assert property (kick_input_oe_o) else $error("weak drive disabled");
	c_trip: cover property (wdog_trip_o);
	c_release: cover property ($fell(rst_o));
	c_self: cover property ($rose(kick_input_o));
endmodule
bind svw_top svw_top_chk #(.HOLD_CYC(HOLD_CYC), .KICK_CYC(KICK_CYC)) svw_top_chk_i (.clk_sys_i(clk_sys_i),
	.rst_i(rst_i), .undervolt_i(undervolt_i), .manual_rst_n_i(manual_rst_n_i), .kick_input_i(kick_input_i),
	.kick_input_o(kick_input_o), .kick_input_oe_o(kick_input_oe_o), .rst_n_o(rst_n_o), .rst_o(rst_o),
	.wdog_trip_o(wdog_trip_o), .cause_o(cause_o));

// ---- tb_top.sv ----
// tb_top.sv: self-checking bench of svw_top with the processor model.
// assumes shortened counts: hold 20 and kick window 64 cycles.
`include "svw_map.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 20;
	localparam int KICK = 64;
	logic                    clk_sys_i = 1'h0;
	logic                    rst_i = 1'h1;
	logic                    undervolt_i = 1'h0;
	logic                    mr_drive = 1'h0;
	logic                    mr_level = 1'h1;
	logic [1:0]              kick_mode = 2'h1;
	logic [7:0]              kick_per = 8'h28;
	wire                     manual_rst_n, kick_wire, kick_o, kick_oe, rst_n_o, rst_o, trip;
	wire [`SVW_CAUSE_W-1:0] cause;
	int                      n_fail = 0;
	int                      checked = 0;
	int                      cyc = 0;
	svw_top #(.HOLD_CYC(HOLD), .KICK_CYC(KICK)) svw_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.undervolt_i(undervolt_i), .manual_rst_n_i(manual_rst_n), .kick_input_i(kick_wire), .kick_input_o(kick_o),
		.kick_input_oe_o(kick_oe), .rst_n_o(rst_n_o), .rst_o(rst_o), .wdog_trip_o(trip), .cause_o(cause));
	svw_cpu_model svw_cpu_model_i (.clk_sys_i(clk_sys_i), .kick_input_o(kick_o), .kick_input_oe_o(kick_oe),
		.mr_drive_i(mr_drive), .mr_level_i(mr_level), .kick_mode_i(kick_mode), .kick_per_i(kick_per),
		.manual_rst_n_o(manual_rst_n), .kick_wire_o(kick_wire));
	task automatic results;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic wait_on(input logic want_trip, output int n);
		n = 0;
		while ((want_trip ? trip !== 1'h1 : rst_o !== 1'h0) && n < 400) begin
			@(negedge clk_sys_i);
			n++;
		end
	endtask
	task automatic t_power;
		int n;
		chk("rst_o", rst_o, 1'h1);
		wait_on(1'h0, n);
		chk("power hold", n >= HOLD - 2 && n <= HOLD + 8, 1'h1);
		chk("rst_n_o", rst_n_o, 1'h1);
	endtask
	task automatic t_uv;
		int n;
		undervolt_i = 1'h1;
		idle(4);
		chk("uv rst_o", rst_o, 1'h1);
		chk("uv rst_n_o", rst_n_o, 1'h0);
		chk("uv cause", cause, 8'h01);
		idle(30);
		undervolt_i = 1'h0;
		idle(10);
		undervolt_i = 1'h1;
		idle(2);
		undervolt_i = 1'h0;
		wait_on(1'h0, n);
		chk("uv hold", n >= HOLD && n <= HOLD + 8, 1'h1);
	endtask
	task automatic t_mr;
		int n;
		mr_drive = 1'h1;
		mr_level = 1'h0;
		idle(2);
		mr_level = 1'h1;
		idle(12);
		chk("glitch", rst_o, 1'h0);
		mr_level = 1'h0;
		idle(40);
		chk("mr rst_o", rst_o, 1'h1);
		chk("mr cause", cause, 8'h02);
		mr_level = 1'h1;
		wait_on(1'h0, n);
		chk("mr hold", n >= HOLD && n <= HOLD + 9, 1'h1);
		mr_drive = 1'h0;
	endtask
	task automatic t_kick(input logic [1:0] m);
		int n;
		int r;
		logic p;
		kick_mode = m;
		n = 0;
		r = 0;
		p = kick_o;
		repeat (400) begin
			@(negedge clk_sys_i);
			if (trip !== 1'h0)
				n++;
			if (kick_o === 1'h1 && p === 1'h0)
				r++;
			p = kick_o;
		end
		chk("no expiry", n, 8'h00);
		if (m == 2'h3)
			chk("self kicks", r >= 5, 1'h1);
	endtask
	task automatic t_expire;
		int n;
		kick_mode = 2'h0;
		wait_on(1'h1, n);
		chk("expiry seen", n > 0 && n < KICK + 45, 1'h1);
		idle(1);
		chk("wd rst_o", rst_o, 1'h1);
		chk("wd cause", cause, 8'h04);
		wait_on(1'h0, n);
		chk("wd hold", n >= HOLD - 2 && n <= HOLD + 3, 1'h1);
		wait_on(1'h1, n);
		chk("count from release", n >= KICK - 3 && n <= KICK + 3, 1'h1);
		kick_mode = 2'h1;
	endtask
	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	// the whole run needs about 1500 cycles
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc > 8000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		idle(2);
		rst_i = 1'h0;
		t_power();
		t_uv();
		t_mr();
		t_kick(2'h1);
		t_kick(2'h2);
		t_kick(2'h3);
		t_expire();
		results();
	end
endmodule
